/* inc/ssop_defines.svh */
// Summary of operation
// - a 64-byte packet buffer holds gesture or proximity results
// - format bit 4 at 0x45 picks which result data is buffered
// - one packet is pushed per output period, rate over averaging factor
// - proximity packets are 2 bytes (intensity) or 6 bytes (x, y, intensity)
// - gesture packets are always 4 bytes
// - a packet is stored only if it fits whole, otherwise dropped
// - stored byte count reads in bits 14:8 at 0x49
// - buffer interrupt when stored word count exceeds threshold at 0x1f
// - buffer interrupt drops by itself once reads lower the level
// - mask bits 7:0 at 0x48, a zero enables that source
// - bit 2 at 0x1c sets interrupt pin behaviour
// - mode nibble at 0x45 bits 3:0, 0xf means idle
// - reads of 0x60 pop buffer words and free their space
// - buffer access only while the fast clock is forced on at 0x32
// - writing bit 15 at 0x49 empties the buffer
// - result registers of a mode refresh together at output period end
// - 16-bit read-only results at 0x00 to 0x06
// - results saturate instead of wrapping
// - sample flags in 0x49 bits 1:0, cleared by writing zero
// - pulse count fields bits 13:8 at 0x21 and 0x23
// - averaging fields at 0x46 bits 6:4 and 2:0
// - sample rate fields at 0x40 bits 3:0 and 7:4
`ifndef SSOP_DEFINES_SVH
`define SSOP_DEFINES_SVH
`define SSOP_R_X1 8'h00
`define SSOP_R_X2 8'h01
`define SSOP_R_Y1 8'h02
`define SSOP_R_Y2 8'h03
`define SSOP_R_PI 8'h04
`define SSOP_R_PX 8'h05
`define SSOP_R_PY 8'h06
`define SSOP_R_IRQCFG 8'h1c
`define SSOP_R_THR 8'h1f
`define SSOP_R_GPULSE 8'h21
`define SSOP_R_PPULSE 8'h23
`define SSOP_R_FCLK 8'h32
`define SSOP_R_RATE 8'h40
`define SSOP_R_MODE 8'h45
`define SSOP_R_AVG 8'h46
`define SSOP_R_MASK 8'h48
`define SSOP_R_STAT 8'h49
`define SSOP_R_BUF 8'h60
`define SSOP_MODE_IDLE 4'hf
`define SSOP_MODE_GEST 4'h8
`define SSOP_MODE_PROX 4'h1
`define SSOP_FLUSH_BIT 15
`define SSOP_IRQPOL_BIT 2
`define SSOP_FCLK_A_BIT 3
`define SSOP_FCLK_B_BIT 11
`define SSOP_ST_GEST 0
`define SSOP_ST_PROX 1
`define SSOP_ST_BUF 7
`define SSOP_MODE_RST 16'h000f
`define SSOP_FCLK_RST 16'h0040
`define SSOP_MASK_RST 16'h00ff
`define SSOP_REG_RST 16'h0000
`define SSOP_BUF_WORDS 32
`define SSOP_CLK_PERIOD_NS 20
`define SSOP_SLOT_BASE_NS 20000
`define SSOP_SLOT_BASE_CYC (`SSOP_SLOT_BASE_NS / `SSOP_CLK_PERIOD_NS)
// bus address value is arbitrary
`define SSOP_I2C_ADDR 7'h2a
`endif

/* inc/ssop_pkg.sv */
package ssop_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WR = 3'b011,
    ST_RD = 3'b100,
    ST_ACK = 3'b101,
    ST_MACK = 3'b110
  } ssop_i2c_st_t;
  typedef struct packed {
    logic [15:0] x1;
    logic [15:0] x2;
    logic [15:0] y1;
    logic [15:0] y2;
    logic [15:0] i;
    logic [15:0] x;
    logic [15:0] y;
  } ssop_sample_t;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [15:0] data;
  } ssop_wr_t;
endpackage

/* hdl/ssop_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ssop_defines.svh"
module ssop_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module ssop_top import ssop_pkg::*; #(
  parameter int SLOT_BASE = `SSOP_SLOT_BASE_CYC,
  parameter logic [6:0] I2C_ADDR = `SSOP_I2C_ADDR
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic irq,
  output logic slot_req,
  input wire logic afe_valid,
  input wire ssop_sample_t afe_data,
  output logic [5:0] pulse_count
);
  logic [2:0] scl_q, sda_q;
  logic rise, fall, start, stop;
  ssop_i2c_st_t st_q, nxt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, in_byte, ptr_q, hi_q, rd_sh_q, rd_lo_byte_q, nb;
  logic ack_on_q, wr_lo_q, rd_lo_q, ld_q, sda_oe_n_q, pop_q, flush_q, load_now;
  ssop_wr_t wr_q;
  logic [15:0] irqcfg_q, thr_q, gpulse_q, ppulse_q, fclk_q, rate_q, mode_q, avg_q, mask_q;
  logic [1:0] sflag_q;
  logic [7:0] stat;
  logic irq_q, slot_q;
  logic [5:0] pulse_q;
  ssop_sample_t res_q, acc_q, base, s_sum;
  logic [7:0] n_q;
  logic [2:0] avg_sel;
  logic [3:0] rate_sel;
  logic done, evt_q, act_g, act_p, buf_ok;
  logic [23:0] tcnt_q, period;
  logic [15:0] pkt_q [3];
  logic [1:0] len_q, idx_q, len_d;
  logic busy_q;
  logic [15:0] fifo_dout;
  logic fifo_ready, fifo_valid;
  logic [5:0] fifo_cnt, free;
  logic [15:0] rd_word;

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hffff : s[15:0];
  endfunction

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    return (p == `SSOP_R_BUF) ? p : p + 8'h01;
  endfunction

  // bus pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end
  assign rise = scl_q[1] && !scl_q[2];
  assign fall = !scl_q[1] && scl_q[2];
  assign start = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
  assign stop = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
  assign in_byte = {sh_q[6:0], sda_q[1]};
  assign nb = rd_lo_q ? rd_lo_byte_q : rd_word[15:8];
  assign load_now = fall && ((st_q == ST_ACK && ack_on_q && nxt_q == ST_RD) ||
                             (st_q == ST_RD && ld_q));

  // bus protocol engine
  always_ff @(posedge clk) begin
    wr_q.en <= 1'b0;
    if (srst) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ack_on_q <= 1'b0;
      ptr_q <= 8'h00;
      hi_q <= 8'h00;
      wr_lo_q <= 1'b0;
      ld_q <= 1'b0;
      rd_sh_q <= 8'h00;
      sda_oe_n_q <= 1'b1;
      wr_q <= '0;
    end else if (start) begin
      st_q <= ST_ADDR;
      bit_q <= 3'h0;
      ack_on_q <= 1'b0;
      wr_lo_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop) begin
      st_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else if (rise) begin
      case (st_q)
        ST_ADDR, ST_REG, ST_WR: begin
          sh_q <= in_byte;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= ST_ACK;
            nxt_q <= ST_WR;
            if (st_q == ST_ADDR) begin
              if (in_byte[7:1] != I2C_ADDR) begin
                st_q <= ST_IDLE;
              end
              nxt_q <= in_byte[0] ? ST_RD : ST_REG;
            end else if (st_q == ST_REG) begin
              ptr_q <= in_byte;
            end else if (!wr_lo_q) begin
              hi_q <= in_byte;
              wr_lo_q <= 1'b1;
            end else begin
              wr_q <= '{en: 1'b1, addr: ptr_q, data: {hi_q, in_byte}};
              wr_lo_q <= 1'b0;
              ptr_q <= ptr_next(ptr_q);
            end
          end
        end
        ST_RD: begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= ST_MACK;
          end
        end
        ST_MACK: begin
          bit_q <= 3'h0;
          st_q <= sda_q[1] ? ST_IDLE : ST_RD;
          ld_q <= !sda_q[1];
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (st_q)
        ST_ACK: begin
          ack_on_q <= !ack_on_q;
          sda_oe_n_q <= ack_on_q;
          if (ack_on_q) begin
            st_q <= nxt_q;
            bit_q <= 3'h0;
          end
        end
        ST_RD: begin
          ld_q <= 1'b0;
          sda_oe_n_q <= rd_sh_q[7];
          rd_sh_q <= {rd_sh_q[6:0], 1'b0};
        end
        ST_MACK: begin
          sda_oe_n_q <= 1'b1;
        end
        default: begin
        end
      endcase
      if (load_now) begin
        sda_oe_n_q <= nb[7];
        rd_sh_q <= {nb[6:0], 1'b0};
        if (rd_lo_q) begin
          ptr_q <= ptr_next(ptr_q);
        end
      end
    end
  end

  // read word assembly and buffer pops
  always_ff @(posedge clk) begin
    pop_q <= 1'b0;
    if (srst || start) begin
      rd_lo_q <= 1'b0;
      rd_lo_byte_q <= 8'h00;
    end else if (load_now) begin
      rd_lo_q <= !rd_lo_q;
      if (!rd_lo_q) begin
        rd_lo_byte_q <= rd_word[7:0];
        pop_q <= (ptr_q == `SSOP_R_BUF) && buf_ok;
      end
    end
  end

  assign buf_ok = fclk_q[`SSOP_FCLK_A_BIT] && fclk_q[`SSOP_FCLK_B_BIT];
  assign stat = {fifo_cnt > {2'b00, thr_q[11:8]}, 5'h00, sflag_q};

  always_comb begin
    rd_word = 16'h0000;
    if (ptr_q == `SSOP_R_X1) begin
      rd_word = res_q.x1;
    end else if (ptr_q == `SSOP_R_X2) begin
      rd_word = res_q.x2;
    end else if (ptr_q == `SSOP_R_Y1) begin
      rd_word = res_q.y1;
    end else if (ptr_q == `SSOP_R_Y2) begin
      rd_word = res_q.y2;
    end else if (ptr_q == `SSOP_R_PI) begin
      rd_word = res_q.i;
    end else if (ptr_q == `SSOP_R_PX) begin
      rd_word = res_q.x;
    end else if (ptr_q == `SSOP_R_PY) begin
      rd_word = res_q.y;
    end else if (ptr_q == `SSOP_R_IRQCFG) begin
      rd_word = irqcfg_q;
    end else if (ptr_q == `SSOP_R_THR) begin
      rd_word = thr_q;
    end else if (ptr_q == `SSOP_R_GPULSE) begin
      rd_word = gpulse_q;
    end else if (ptr_q == `SSOP_R_PPULSE) begin
      rd_word = ppulse_q;
    end else if (ptr_q == `SSOP_R_FCLK) begin
      rd_word = fclk_q;
    end else if (ptr_q == `SSOP_R_RATE) begin
      rd_word = rate_q;
    end else if (ptr_q == `SSOP_R_MODE) begin
      rd_word = mode_q;
    end else if (ptr_q == `SSOP_R_AVG) begin
      rd_word = avg_q;
    end else if (ptr_q == `SSOP_R_MASK) begin
      rd_word = mask_q;
    end else if (ptr_q == `SSOP_R_STAT) begin
      rd_word = {1'b0, fifo_cnt, 1'b0, stat};
    end else if (ptr_q == `SSOP_R_BUF) begin
      rd_word = (buf_ok && fifo_valid) ? fifo_dout : 16'h0000;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      irqcfg_q <= `SSOP_REG_RST;
      thr_q <= `SSOP_REG_RST;
      gpulse_q <= `SSOP_REG_RST;
      ppulse_q <= `SSOP_REG_RST;
      fclk_q <= `SSOP_FCLK_RST;
      rate_q <= `SSOP_REG_RST;
      mode_q <= `SSOP_MODE_RST;
      avg_q <= `SSOP_REG_RST;
      mask_q <= `SSOP_MASK_RST;
    end else if (wr_q.en) begin
      if (wr_q.addr == `SSOP_R_IRQCFG) begin
        irqcfg_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_THR) begin
        thr_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_GPULSE) begin
        gpulse_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_PPULSE) begin
        ppulse_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_FCLK) begin
        fclk_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_RATE) begin
        rate_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_MODE) begin
        mode_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_AVG) begin
        avg_q <= wr_q.data;
      end else if (wr_q.addr == `SSOP_R_MASK) begin
        mask_q <= wr_q.data;
      end
    end
  end

  // sample flags, flush and interrupt pin
  always_ff @(posedge clk) begin
    if (srst) begin
      sflag_q <= 2'b00;
      flush_q <= 1'b0;
      irq_q <= 1'b1;
    end else begin
      flush_q <= wr_q.en && wr_q.addr == `SSOP_R_STAT &&
                 wr_q.data[`SSOP_FLUSH_BIT] && buf_ok;
      if (wr_q.en && wr_q.addr == `SSOP_R_STAT) begin
        sflag_q <= (sflag_q & wr_q.data[1:0]) | {evt_q && act_p, evt_q && act_g};
      end else begin
        sflag_q <= sflag_q | {evt_q && act_p, evt_q && act_g};
      end
      irq_q <= !((|(stat & ~mask_q[7:0])) ^ irqcfg_q[`SSOP_IRQPOL_BIT]);
    end
  end

  assign act_g = mode_q[3:0] == `SSOP_MODE_GEST;
  assign act_p = mode_q[3:0] == `SSOP_MODE_PROX;
  assign rate_sel = act_p ? rate_q[7:4] : rate_q[3:0];
  assign period = 24'(SLOT_BASE * (16 - int'(rate_sel)));

  // slot timer and pulse setup to the front end
  always_ff @(posedge clk) begin
    if (srst || !(act_g || act_p)) begin
      tcnt_q <= 24'h000000;
      slot_q <= 1'b0;
    end else if (tcnt_q >= period - 24'h000001) begin
      tcnt_q <= 24'h000000;
      slot_q <= 1'b1;
    end else begin
      tcnt_q <= tcnt_q + 24'h000001;
      slot_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_q <= 6'h00;
    end else begin
      pulse_q <= act_p ? ppulse_q[13:8] : gpulse_q[13:8];
    end
  end

  assign avg_sel = act_p ? avg_q[2:0] : avg_q[6:4];
  assign done = n_q == 8'(8'h01 << avg_sel) - 8'h01;
  assign base = (n_q == 8'h00) ? '0 : acc_q;
  always_comb begin
    s_sum.x1 = sat_add(base.x1, afe_data.x1);
    s_sum.x2 = sat_add(base.x2, afe_data.x2);
    s_sum.y1 = sat_add(base.y1, afe_data.y1);
    s_sum.y2 = sat_add(base.y2, afe_data.y2);
    s_sum.i = sat_add(base.i, afe_data.i);
    s_sum.x = sat_add(base.x, afe_data.x);
    s_sum.y = sat_add(base.y, afe_data.y);
  end

  // averaging and result registers
  always_ff @(posedge clk) begin
    evt_q <= 1'b0;
    if (srst) begin
      n_q <= 8'h00;
      acc_q <= '0;
      res_q <= '0;
    end else if (!(act_g || act_p)) begin
      n_q <= 8'h00;
    end else if (afe_valid) begin
      acc_q <= s_sum;
      n_q <= done ? 8'h00 : n_q + 8'h01;
      if (done) begin
        evt_q <= 1'b1;
        if (act_g) begin
          res_q.x1 <= s_sum.x1;
          res_q.x2 <= s_sum.x2;
          res_q.y1 <= s_sum.y1;
          res_q.y2 <= s_sum.y2;
        end else begin
          res_q.i <= s_sum.i;
          res_q.x <= s_sum.x;
          res_q.y <= s_sum.y;
        end
      end
    end
  end

  // packet writer
  assign free = 6'(`SSOP_BUF_WORDS) - fifo_cnt;
  assign len_d = act_g ? 2'd2 : (mode_q[4] ? 2'd3 : 2'd1);
  always_ff @(posedge clk) begin
    if (srst || flush_q) begin
      busy_q <= 1'b0;
      idx_q <= 2'd0;
      len_q <= 2'd0;
      pkt_q <= '{default: 16'h0000};
    end else if (!busy_q) begin
      if (evt_q && free >= {4'h0, len_d}) begin
        busy_q <= 1'b1;
        idx_q <= 2'd0;
        len_q <= len_d;
        if (act_g) begin
          pkt_q[0] <= mode_q[4] ? res_q.y1 : res_q.x1;
          pkt_q[1] <= mode_q[4] ? res_q.y2 : res_q.x2;
          pkt_q[2] <= 16'h0000;
        end else if (mode_q[4]) begin
          pkt_q[0] <= res_q.x;
          pkt_q[1] <= res_q.y;
          pkt_q[2] <= res_q.i;
        end else begin
          pkt_q[0] <= res_q.i;
          pkt_q[1] <= 16'h0000;
          pkt_q[2] <= 16'h0000;
        end
      end
    end else if (fifo_ready) begin
      idx_q <= idx_q + 2'd1;
      busy_q <= idx_q != len_q - 2'd1;
    end
  end

  ssop_fifo #(.W(16), .D(`SSOP_BUF_WORDS)) u_fifo (
    .clk(clk),
    .srst(srst),
    .flush(flush_q),
    .in_valid(busy_q),
    .in_ready(fifo_ready),
    .in_data(pkt_q[idx_q]),
    .out_valid(fifo_valid),
    .out_ready(pop_q),
    .out_data(fifo_dout),
    .count(fifo_cnt)
  );

  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_q;
  assign irq = irq_q;
  assign slot_req = slot_q;
  assign pulse_count = pulse_q;
endmodule
`default_nettype wire

/* tb/ssop_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ssop_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic irq,
  input wire logic slot_req,
  input wire logic afe_valid,
  input wire logic [5:0] pulse_count
);
  logic [3:0] quiet_q;
  // cycles since the last bus edge or front end result
  always_ff @(posedge clk) begin
    if (srst || afe_valid || $changed(scl_i) || $changed(sda_i)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_sda_value_low: assert property (sda_o == 1'b0)
    else $error("sda data value not low");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_bus_idle_release: assert property (quiet_q == 4'hf && scl_i |-> sda_oe_n)
    else $error("sda driven on idle bus");
  a_slot_gap: assert property (slot_req |=> !slot_req [*8])
    else $error("slot starts too close");
  a_irq_quiet: assert property (quiet_q == 4'hf |-> $stable(irq))
    else $error("irq moved without a cause");
  a_pulse_quiet: assert property (quiet_q == 4'hf |-> $stable(pulse_count))
    else $error("pulse count moved without a write");
  a_reset_idle: assert property ($fell(srst) |-> sda_oe_n && !slot_req && pulse_count == 6'h00)
    else $error("outputs not idle after reset");
  a_irq_reset_off: assert property ($fell(srst) |-> irq)
    else $error("irq active after reset");
endmodule
bind ssop_top ssop_assertions u_ssop_assertions (.clk(clk), .srst(srst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq), .slot_req(slot_req),
  .afe_valid(afe_valid), .pulse_count(pulse_count));
`default_nettype wire

/* tb/ssop_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ssop_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic m_low
);
  logic [6:0] dev;
  logic nak;
  logic [15:0] got [$];
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
    dev = 7'h2a;
    nak = 1'b0;
  end
  task automatic hp();
    repeat (5) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    m_low <= !b;
    hp();
    scl <= 1'b1;
    hp();
    s = sda;
    scl <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q);
    logic s;
    for (int b = 7; b >= 0; b--) bit_io(d[b], q[b]);
    bit_io(a, s);
    if (a && s) nak = 1'b1;
  endtask
  task automatic start();
    m_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    m_low <= 1'b1;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    m_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    m_low <= 1'b0;
    hp();
  endtask
  task automatic wr(input logic [7:0] r, input logic [15:0] d);
    logic [7:0] q;
    nak = 1'b0;
    start();
    byte_io({dev, 1'b0}, 1'b1, q);
    byte_io(r, 1'b1, q);
    byte_io(d[15:8], 1'b1, q);
    byte_io(d[7:0], 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, input int n);
    logic [7:0] h;
    logic [7:0] l;
    got.delete();
    start();
    byte_io({dev, 1'b0}, 1'b1, h);
    byte_io(r, 1'b1, h);
    start();
    byte_io({dev, 1'b1}, 1'b1, h);
    for (int j = 0; j < n; j++) begin
      byte_io(8'hff, 1'b0, h);
      byte_io(8'hff, j == n - 1, l);
      got.push_back({h, l});
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module testbench import ssop_pkg::*; ();
  logic clk, srst, scl_i, sda_i, sda_o, sda_oe_n, irq, slot_req, afe_valid, m_low;
  ssop_sample_t afe_data;
  logic [5:0] pulse_count;
  int fails, comparisons;
  logic [7:0] ra [10];
  logic [15:0] rw [10];
  logic [15:0] re [10];
  assign sda_i = !(m_low || !sda_oe_n);
  ssop_host u_ssop_host (.clk(clk), .sda(sda_i), .scl(scl_i), .m_low(m_low));
  ssop_top #(.SLOT_BASE(10)) u_ssop_top (.clk(clk), .srst(srst), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq), .slot_req(slot_req),
    .afe_valid(afe_valid), .afe_data(afe_data), .pulse_count(pulse_count));
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    u_ssop_host.wr(a, d);
  endtask
  task automatic r(input logic [7:0] a, input int n);
    u_ssop_host.rd(a, n);
  endtask
  task automatic cnt(input logic [6:0] e);
    r(8'h49, 1);
    `CHK("count", e, u_ssop_host.got[0][14:8])
  endtask
  task automatic fire(input logic [7:0] k);
    int n;
    n = 0;
    while (slot_req !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    `CHK("slot", 1'b1, slot_req)
    @(posedge clk);
    afe_valid <= 1'b1;
    afe_data <= '{16'h1000 + k, 16'h2000 + k, 16'h3000 + k, 16'h3800 + k,
      16'h4000 + k, 16'h5000 + k, 16'h6000 + k};
    @(posedge clk);
    afe_valid <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    afe_valid = 1'b0;
    afe_data = '0;
    ra = '{8'h1c, 8'h1f, 8'h21, 8'h23, 8'h40, 8'h46, 8'h48, 8'h32, 8'h00, 8'h07};
    rw = '{16'h0004, 16'h0200, 16'h2a00, 16'h1500, 16'h00ee, 16'h0000, 16'h007f,
      16'h0f4f, 16'hffff, 16'hffff};
    re = rw;
    re[8] = 16'h0000;
    re[9] = 16'h0000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      w(ra[k], rw[k]);
      r(ra[k], 1);
      `CHK("register", re[k], u_ssop_host.got[0])
    end
    `CHK("pulse", 6'h2a, pulse_count)
    $display("test registers done");
    u_ssop_host.dev = 7'h2b;
    w(8'h45, 16'h0008);
    `CHK("nack", 1'b1, u_ssop_host.nak)
    u_ssop_host.dev = 7'h2a;
    r(8'h45, 1);
    `CHK("mode", 16'h000f, u_ssop_host.got[0])
    $display("test address done");
    w(8'h45, 16'h0008);
    fire(0);
    cnt(7'h04);
    `CHK("irq", 1'b0, irq)
    fire(1);
    `CHK("irq", 1'b1, irq)
    for (int k = 2; k < 17; k++) fire(k[7:0]);
    cnt(7'h40);
    `CHK("flag", 1'b1, u_ssop_host.got[0][0])
    r(8'h00, 1);
    `CHK("x1", 16'h1010, u_ssop_host.got[0])
    w(8'h48, 16'h00ff);
    `CHK("irq", 1'b0, irq)
    w(8'h48, 16'h007f);
    `CHK("irq", 1'b1, irq)
    w(8'h49, 16'h0000);
    r(8'h49, 1);
    `CHK("flag", 1'b0, u_ssop_host.got[0][0])
    r(8'h60, 32);
    for (int k = 0; k < 16; k++) begin
      `CHK("word", 16'h1000 + k[15:0], u_ssop_host.got[2 * k])
      `CHK("word", 16'h2000 + k[15:0], u_ssop_host.got[2 * k + 1])
    end
    `CHK("irq", 1'b0, irq)
    r(8'h60, 1);
    `CHK("empty", 16'h0000, u_ssop_host.got[0])
    cnt(7'h00);
    $display("test gesture done");
    w(8'h45, 16'h0011);
    fire(0);
    cnt(7'h06);
    w(8'h45, 16'h0001);
    fire(1);
    cnt(7'h08);
    `CHK("pulse", 6'h15, pulse_count)
    w(8'h32, 16'h0040);
    r(8'h60, 1);
    `CHK("slow", 16'h0000, u_ssop_host.got[0])
    cnt(7'h08);
    w(8'h32, 16'h0f4f);
    r(8'h60, 4);
    `CHK("px", 16'h5000, u_ssop_host.got[0])
    `CHK("py", 16'h6000, u_ssop_host.got[1])
    `CHK("pi", 16'h4000, u_ssop_host.got[2])
    `CHK("pi", 16'h4001, u_ssop_host.got[3])
    fire(2);
    w(8'h45, 16'h000f);
    w(8'h49, 16'h8000);
    cnt(7'h00);
    $display("test proximity done");
    w(8'h46, 16'h0030);
    w(8'h45, 16'h0008);
    for (int k = 0; k < 7; k++) fire(k[7:0]);
    cnt(7'h00);
    fire(7);
    cnt(7'h04);
    r(8'h00, 4);
    `CHK("sum", 16'h801c, u_ssop_host.got[0])
    `CHK("clip", 16'hffff, u_ssop_host.got[1])
    `CHK("clip", 16'hffff, u_ssop_host.got[2])
    `CHK("clip", 16'hffff, u_ssop_host.got[3])
    $display("test averaging done");
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    r(8'h45, 1);
    `CHK("mode", 16'h000f, u_ssop_host.got[0])
    r(8'h32, 1);
    `CHK("fclk", 16'h0040, u_ssop_host.got[0])
    r(8'h48, 1);
    `CHK("mask", 16'h00ff, u_ssop_host.got[0])
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
